// [pev_vectoring.sv]
// module: privilege mode, space codes and exception vector generation
//
// Contract
// [RL1] user mode rises only via exception entry
// [RL2] entry saves supervisor flag then sets it
// [RL3] four instructions may drop to user mode; the return write is refused unless hasBase is set
// [RL4] return pops status and pc, resumes
// [RL5] status writes fetch operands as supervisor
// [RL6] space codes encode user/supervisor data/program
// [RL7] codes 000, 011, 100 never driven
// [RL8] acknowledge cycles use processor space code
// [RL9] entry runs four ordered steps
// [RL10] vectors supervisor data; reset supervisor program
// [RL11] vector number eight bits, scaled by four
// [RL12] acknowledge vector from low data lanes
// [RL13] offset is number shifted left, zero filled
// [RL14] address adds vector base, reset to zero
// [RL15] address truncated to bus width
// [RL16] table spans bytes 0 to 1023
// [RL17] autovector levels 1..7 use 25..31
// [RL18] acknowledge bus error gives vector 24
// [RL19] trap n uses vector 32 plus n
// [RL20] user interrupt vectors 64 to 255
// [RL21] peripherals avoid reserved vector numbers
// [RL22] internal and external causes raise exceptions
// [RL23] fixed vector numbers per cause
// [RL24] supervisor flag set means supervisor references
`timescale 1ns/100ps
`default_nettype none
module pev_vectoring
  (
  input  wire logic              sys_clk,      // 10 MHz core clock
  input  wire logic              nrst,         // sync reset, active low
  input  wire logic              clkEn,        // freezes all state when low
  input  wire logic              excReq,       // exception request pulse
  input  wire pev_pkg::pev_cause_t excCause,   // cause of the request
  input  wire logic [2:0]        irqLevel,     // interrupt level 1..7
  input  wire logic              irqAuto,      // use autovector
  input  wire logic [3:0]        trapNum,      // trap operand n
  input  wire logic              ackDone,      // acknowledge cycle ended
  input  wire logic              ackBusErr,    // bus error on acknowledge
  input  wire logic [15:0]       ackData,      // data bus during ack
  input  wire logic              saveDone,     // context stacked
  input  wire logic              fetchDone,    // vector fetched
  input  wire logic              swWrite,      // status-word write request
  input  wire pev_pkg::pev_swop_t swOp,        // write operation kind
  input  wire logic [15:0]       swOperand,    // operand or popped value
  input  wire logic              baseWrite,    // control_register_move
  input  wire logic [31:0]       baseValue,    // new vector_base value
  input  wire logic              refProgram,   // current ref is a fetch
  input  wire logic              refOperand,   // ref is a status operand
  input  wire logic              hasBase,      // base-register variant
  output var  logic [15:0]       statusWord,   // live status_word
  output var  logic [15:0]       savedStatus,  // copy taken on entry
  output var  logic              spaceCodeHigh,// space_code_high
  output var  logic              spaceCodeMid, // space_code_mid
  output var  logic              spaceCodeLow, // space_code_low
  output var  logic [7:0]        vecNum,       // vector number
  output var  logic [pev_pkg::ADDR_W_WIDE-1:0] vecAddr, // truncated addr
  output var  logic              ackCycle,     // acknowledge cycle active
  output var  logic              saveStep,     // context save step
  output var  logic              fetchStep,    // vector fetch step
  output var  logic              swRefused     // status write refused
  );

  // entry sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_VECTOR, ST_ACK, ST_SAVE, ST_FETCH
  } pev_state_t;

  pev_state_t  state_q, state_d;     // sequencer state
  logic [15:0] sw_q, sw_d;           // status_word
  logic [15:0] swSave_q, swSave_d;   // copy of status word
  logic [31:0] base_q, base_d;       // vector_base
  logic [7:0]  vec_q, vec_d;         // vector number
  logic        isReset_q, isReset_d; // reset entry in flight
  logic [2:0]  spc_q;                // registered space code
  logic [pev_pkg::ADDR_W_WIDE-1:0] addr_q; // registered address
  logic        refused_q;            // refused write flag

  // fixed vector number for an internally numbered cause
  function automatic logic [7:0] fixedVec(input pev_pkg::pev_cause_t c,
                                          input logic [3:0] n);
    logic [7:0] v;
    v = pev_pkg::VEC_UNINIT_IRQ;
    case (c)
      pev_pkg::CAUSE_RESET:      v = pev_pkg::VEC_RESET_SSP;  // RL23
      pev_pkg::CAUSE_BUS_ERR:    v = pev_pkg::VEC_BUS_ERR;    // RL23
      pev_pkg::CAUSE_ADDR_ERR:   v = pev_pkg::VEC_ADDR_ERR;
      pev_pkg::CAUSE_ILLEGAL:    v = pev_pkg::VEC_ILLEGAL;    // RL22
      pev_pkg::CAUSE_ZERO_DIV:   v = pev_pkg::VEC_ZERO_DIV;
      pev_pkg::CAUSE_BOUNDS:     v = pev_pkg::VEC_BOUNDS;
      pev_pkg::CAUSE_OVF_TRAP:   v = pev_pkg::VEC_OVF_TRAP;
      pev_pkg::CAUSE_PRIV_VIOL:  v = pev_pkg::VEC_PRIV_VIOL;
      pev_pkg::CAUSE_TRACE:      v = pev_pkg::VEC_TRACE;
      pev_pkg::CAUSE_LINE_A:     v = pev_pkg::VEC_LINE_A;
      pev_pkg::CAUSE_LINE_F:     v = pev_pkg::VEC_LINE_F;
      pev_pkg::CAUSE_FORMAT_ERR: v = pev_pkg::VEC_FORMAT_ERR;
      pev_pkg::CAUSE_TRAP:       v = pev_pkg::VEC_TRAP_BASE + {4'h0, n}; // RL19
      default:                   v = pev_pkg::VEC_UNINIT_IRQ;
    endcase
    return v;
  endfunction

  // decode of current mode and request qualifiers
  wire        supvMode   = sw_q[pev_pkg::SW_SUPV_BIT];          // RL24
  wire        idle       = (state_q == ST_IDLE);
  wire        startEntry = clkEn && idle && excReq;
  wire        isIrq      = (excCause == pev_pkg::CAUSE_IRQ);
  // user-mode status writes refused; only exception entry lifts mode
  wire        swAllowed  = swWrite && idle && !excReq && supvMode; // RL1 RL3
  wire        baseOk     = baseWrite && idle && !excReq &&
                           supvMode && hasBase;               // RL14

  // new status word for each write kind
  wire [15:0] swAndVal   = sw_q & swOperand;
  wire [15:0] swXorVal   = sw_q ^ swOperand;
  wire        rteOk      = (swOp != pev_pkg::SWOP_RETURN) || hasBase; // RL3
  wire [15:0] swNewVal   = (swOp == pev_pkg::SWOP_AND) ? swAndVal :
                           (swOp == pev_pkg::SWOP_XOR) ? swXorVal :
                           swOperand;                         // RL4 RL5
  // any status write not taken while clock enable is high is reported as refused
  wire        swRefuseNow = swWrite && !(swAllowed && rteOk); // RL1 RL3

  // acknowledge vector: low lanes, autovector or spurious
  wire [7:0]  ackLow     = ackData[7:0];   // low_data_lanes, upper ignored
  wire [7:0]  autoVec    = pev_pkg::VEC_AUTO_BASE + {5'h00, irqLevel}; // RL17
  wire [7:0]  ackVec     = ackBusErr ? pev_pkg::VEC_SPURIOUS :  // RL18
                           irqAuto   ? autoVec :
                           ackLow;                            // RL12 RL20

  // offset, base add and truncation
  wire [31:0] vecOffset  = {22'h000000, vec_q, 2'h0};        // RL11 RL13 RL16
  wire [31:0] vecAbs     = hasBase ? (base_q + vecOffset) : vecOffset; // RL14
  wire [pev_pkg::ADDR_W_WIDE-1:0] vecTrunc =
                           vecAbs[pev_pkg::ADDR_W_WIDE-1:0];   // RL15

  // space code for the current reference
  wire [2:0]  spcNext    =
    (state_q == ST_ACK)               ? pev_pkg::SPC_PROC_SPACE :   // RL8
    (state_q == ST_FETCH && isReset_q) ? pev_pkg::SPC_SUPV_PROG :   // RL10
    (state_q == ST_FETCH || state_q == ST_SAVE) ? pev_pkg::SPC_SUPV_DATA :
    (refOperand || supvMode) ?                                     // RL5
      (refProgram ? pev_pkg::SPC_SUPV_PROG : pev_pkg::SPC_SUPV_DATA) :
      (refProgram ? pev_pkg::SPC_USER_PROG : pev_pkg::SPC_USER_DATA); // RL6 RL7

  // sequencer and register next-state logic
  always_comb
  begin
    state_d   = state_q;
    sw_d      = sw_q;
    swSave_d  = swSave_q;
    base_d    = base_q;
    vec_d     = vec_q;
    isReset_d = isReset_q;
    case (state_q)
      ST_IDLE:
      begin
        if (excReq)
        begin
          // step one: copy status, enter supervisor, stop tracing
          swSave_d = sw_q;                                    // RL2 RL9
          sw_d     = sw_q;
          sw_d[pev_pkg::SW_SUPV_BIT]  = 1'b1;                 // RL2 RL1
          sw_d[pev_pkg::SW_TRACE_BIT] = 1'b0;
          isReset_d = (excCause == pev_pkg::CAUSE_RESET);
          state_d   = isIrq ? ST_ACK : ST_VECTOR;             // RL9 RL22
          vec_d     = fixedVec(excCause, trapNum);
        end
        else if (swAllowed && rteOk)
          sw_d = swNewVal;                                    // RL3 RL4 RL5
        if (baseOk)
          base_d = baseValue;                                 // RL14
      end
      ST_VECTOR:
        state_d = isReset_q ? ST_FETCH : ST_SAVE;             // RL9
      ST_ACK:
      begin
        if (ackDone)
        begin
          vec_d   = ackVec;                                   // RL12 RL18
          state_d = ST_SAVE;
        end
      end
      ST_SAVE:
        if (saveDone)
          state_d = ST_FETCH;                                 // RL9
      ST_FETCH:
        if (fetchDone)
          state_d = ST_IDLE;                                  // RL9
      default:
        state_d = ST_IDLE;
    endcase
  end

  // state registers, frozen while clock enable is low
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_q   <= ST_IDLE;
      sw_q      <= pev_pkg::SW_RESET;
      swSave_q  <= pev_pkg::SW_RESET;
      base_q    <= 32'h00000000;
      vec_q     <= 8'h00;
      isReset_q <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q   <= state_d;
      sw_q      <= sw_d;
      swSave_q  <= swSave_d;
      base_q    <= base_d;
      vec_q     <= vec_d;
      isReset_q <= isReset_d;
    end
  end

  // registered outputs
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      spc_q     <= pev_pkg::SPC_SUPV_PROG;
      addr_q    <= '0;
      refused_q <= 1'b0;
    end
    else if (clkEn)
    begin
      spc_q     <= spcNext;                                   // RL6
      addr_q    <= vecTrunc;                                  // RL15
      refused_q <= swRefuseNow;                               // RL1
    end
  end

  // output registers, loaded from next-state values on the same edge as the state registers
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      statusWord  <= pev_pkg::SW_RESET;
      savedStatus <= pev_pkg::SW_RESET;
      vecNum      <= 8'h00;
      ackCycle    <= 1'b0;
      saveStep    <= 1'b0;
      fetchStep   <= 1'b0;
    end
    else if (clkEn)
    begin
      statusWord  <= sw_d;
      savedStatus <= swSave_d;
      vecNum      <= vec_d;
      ackCycle    <= (state_d == ST_ACK);
      saveStep    <= (state_d == ST_SAVE);
      fetchStep   <= (state_d == ST_FETCH);
    end
  end

  assign spaceCodeHigh = spc_q[2];
  assign spaceCodeMid  = spc_q[1];
  assign spaceCodeLow  = spc_q[0];
  assign vecAddr       = addr_q;
  assign swRefused     = refused_q;

  // checks on observable behaviour
  a_user_no_raise: assert property ( // RL1
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && !supvMode && !startEntry |=> !supvMode)
    else $error("privilege rose without exception entry");
  a_user_refused: assert property ( // RL1
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && swWrite && idle && !excReq && !supvMode
      |=> swRefused && $stable(sw_q))
    else $error("user status write not refused");
  a_entry_sets_supv: assert property ( // RL2
    @(posedge sys_clk) disable iff (!nrst)
    startEntry |=> supvMode && swSave_q == $past(sw_q))
    else $error("entry did not save and set supervisor flag");
  a_entry_trace: assert property ( // RL9
    @(posedge sys_clk) disable iff (!nrst)
    startEntry |=> !sw_q[pev_pkg::SW_TRACE_BIT])
    else $error("tracing left on after entry");
  a_return_gate: assert property ( // RL3
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && swWrite && swOp == pev_pkg::SWOP_RETURN && !hasBase
      |=> swRefused)
    else $error("return accepted without vector base");
  a_move_value: assert property ( // RL5
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && swAllowed && swOp == pev_pkg::SWOP_MOVE
      |=> sw_q == $past(swOperand))
    else $error("status move not loaded");
  a_operand_supv: assert property ( // RL5
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && idle && refOperand |=> spaceCodeHigh)
    else $error("status operand not a supervisor reference");
  a_space_legal: assert property ( // RL7
    @(posedge sys_clk) disable iff (!nrst)
    spc_q != 3'h0 && spc_q != 3'h3 && spc_q != 3'h4)
    else $error("reserved space code driven");
  a_ack_space: assert property ( // RL8
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_ACK |=> spc_q == pev_pkg::SPC_PROC_SPACE)
    else $error("acknowledge not in processor space");
  a_reset_prog: assert property ( // RL10
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_FETCH && isReset_q
      |=> spc_q == pev_pkg::SPC_SUPV_PROG)
    else $error("reset vector not in supervisor program");
  a_fetch_space: assert property ( // RL10
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_FETCH && !isReset_q
      |=> spc_q == pev_pkg::SPC_SUPV_DATA)
    else $error("vector fetch not in supervisor data");
  a_ack_lanes: assert property ( // RL12
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_ACK && ackDone && !ackBusErr && !irqAuto
      |=> vec_q == $past(ackLow))
    else $error("supplied vector not taken from low lanes");
  a_offset_form: assert property ( // RL13
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && !hasBase |=> addr_q == {14'h0000, $past(vec_q), 2'h0})
    else $error("vector offset wrong");
  a_base_reset: assert property ( // RL14
    @(posedge sys_clk)
    !nrst |=> base_q == 32'h00000000)
    else $error("vector base not cleared on reset");
  a_auto_vec: assert property ( // RL17
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_ACK && ackDone && !ackBusErr && irqAuto
      |=> vec_q == 8'h18 + {5'h00, $past(irqLevel)})
    else $error("autovector number wrong");
  a_spurious_vec: assert property ( // RL18
    @(posedge sys_clk) disable iff (!nrst)
    clkEn && state_q == ST_ACK && ackDone && ackBusErr
      |=> vec_q == 8'h18)
    else $error("spurious vector not taken");
  a_trap_vec: assert property ( // RL19
    @(posedge sys_clk) disable iff (!nrst)
    startEntry && excCause == pev_pkg::CAUSE_TRAP
      |=> vec_q == 8'h20 + {4'h0, $past(trapNum)})
    else $error("trap vector number wrong");
  c_irq_entry: cover property (@(posedge sys_clk) disable iff (!nrst)
    state_q == ST_ACK ##1 state_q == ST_SAVE);
  c_reset_entry: cover property (@(posedge sys_clk) disable iff (!nrst)
    isReset_q && state_q == ST_FETCH);
  c_drop_user: cover property (@(posedge sys_clk) disable iff (!nrst)
    sw_q[pev_pkg::SW_SUPV_BIT] ##1 !sw_q[pev_pkg::SW_SUPV_BIT]);
  c_spurious: cover property (@(posedge sys_clk) disable iff (!nrst)
    state_q == ST_ACK && ackDone && ackBusErr);
  c_base_fetch: cover property (@(posedge sys_clk) disable iff (!nrst)
    hasBase && state_q == ST_FETCH && base_q != 32'h00000000);
endmodule
`default_nettype wire

// [pev_pkg.sv]
// package: constants and types for privilege and exception vectoring
package pev_pkg;
  // space codes on the three space-code outputs (high to low)
  localparam logic [2:0] SPC_USER_DATA  = 3'h1;
  localparam logic [2:0] SPC_USER_PROG  = 3'h2;
  localparam logic [2:0] SPC_SUPV_DATA  = 3'h5;
  localparam logic [2:0] SPC_SUPV_PROG  = 3'h6;
  localparam logic [2:0] SPC_PROC_SPACE = 3'h7;
  // status word field positions and reset value
  localparam int          SW_SUPV_BIT  = 13;
  localparam int          SW_TRACE_BIT = 15;
  localparam logic [15:0] SW_RESET     = 16'h2700;
  // fixed vector numbers
  localparam logic [7:0] VEC_RESET_SSP  = 8'h00;
  localparam logic [7:0] VEC_RESET_PC   = 8'h01;
  localparam logic [7:0] VEC_BUS_ERR    = 8'h02;
  localparam logic [7:0] VEC_ADDR_ERR   = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0] VEC_ZERO_DIV   = 8'h05;
  localparam logic [7:0] VEC_BOUNDS     = 8'h06;
  localparam logic [7:0] VEC_OVF_TRAP   = 8'h07;
  localparam logic [7:0] VEC_PRIV_VIOL  = 8'h08;
  localparam logic [7:0] VEC_TRACE      = 8'h09;
  localparam logic [7:0] VEC_LINE_A     = 8'h0a;
  localparam logic [7:0] VEC_LINE_F     = 8'h0b;
  localparam logic [7:0] VEC_FORMAT_ERR = 8'h0e;
  localparam logic [7:0] VEC_UNINIT_IRQ = 8'h0f;
  localparam logic [7:0] VEC_SPURIOUS   = 8'h18;
  localparam logic [7:0] VEC_AUTO_BASE  = 8'h18;
  localparam logic [7:0] VEC_TRAP_BASE  = 8'h20;
  localparam logic [7:0] VEC_USER_FIRST = 8'h40;
  // bus widths
  localparam int ADDR_W_WIDE   = 24;
  localparam int ADDR_W_NARROW = 22; // narrow bus keeps low 22 or 20 bits
  // exception causes
  typedef enum logic [3:0] {
    CAUSE_RESET, CAUSE_BUS_ERR, CAUSE_ADDR_ERR, CAUSE_ILLEGAL,
    CAUSE_ZERO_DIV, CAUSE_BOUNDS, CAUSE_OVF_TRAP, CAUSE_PRIV_VIOL,
    CAUSE_TRACE, CAUSE_LINE_A, CAUSE_LINE_F, CAUSE_FORMAT_ERR,
    CAUSE_IRQ, CAUSE_TRAP
  } pev_cause_t;
  // status-word write operations
  typedef enum logic [1:0] {
    SWOP_MOVE, SWOP_AND, SWOP_XOR, SWOP_RETURN
  } pev_swop_t;
endpackage

// [pev_far_model.sv]
// far-side model: acknowledging peripheral, stack memory and vector memory
`timescale 1ns/100ps
`default_nettype none
module pev_far_model
  (
  input  wire logic        sys_clk,   // core clock
  input  wire logic [2:0]  spaceCode, // space code, high to low
  input  wire logic        ackCycle,  // acknowledge step active
  input  wire logic        saveStep,  // context save step active
  input  wire logic        fetchStep, // vector fetch step active
  input  wire logic [7:0]  vecByte,   // vector this peripheral hands back
  input  wire logic        failAck,   // end acknowledge with bus error
  input  wire logic [3:0]  waitCyc,   // answer delay in cycles
  output var  logic        ackDone,   // acknowledge ended
  output var  logic        ackBusErr, // bus error on acknowledge
  output var  logic [15:0] ackData,   // data bus
  output var  logic        saveDone,  // context stacked
  output var  logic        fetchDone  // vector fetched
  );
  int cnt; // cycles spent in the current step
  logic live; // a step that this model must answer
  initial
  begin
    cnt = 0;
    ackDone = 1'b0;
    ackBusErr = 1'b0;
    ackData = 16'h5a5a;
    saveDone = 1'b0;
    fetchDone = 1'b0;
  end
  // an acknowledge is only recognised by the processor space code
  assign live = (ackCycle && spaceCode == 3'h7) || saveStep || fetchStep;
  // answers each step after waitCyc cycles with a one-cycle pulse
  always @(negedge sys_clk)
  begin
    ackDone <= 1'b0;
    ackBusErr <= 1'b0;
    saveDone <= 1'b0;
    fetchDone <= 1'b0;
    ackData <= ~ackData; // released bus keeps toggling
    if (!live)
      cnt <= 0;
    else if (cnt < waitCyc || ackDone || saveDone || fetchDone)
      cnt <= cnt + 1;
    else
    begin
      cnt <= 0;
      ackDone <= ackCycle;
      ackBusErr <= ackCycle && failAck;
      saveDone <= saveStep && !ackCycle;
      fetchDone <= fetchStep && !ackCycle && !saveStep;
      if (ackCycle)
        ackData <= {~vecByte, vecByte};
    end
  end
endmodule
`default_nettype wire

// [privilege_and_exception_vectoring_tb_top.sv]
// testbench for privilege mode, space codes and vector generation
`timescale 1ns/100ps
`default_nettype none
module privilege_and_exception_vectoring_tb_top;
  logic sys_clk, nrst, clkEn, excReq, irqAuto, ackDone, ackBusErr;
  logic saveDone, fetchDone, swWrite, baseWrite, refProgram, refOperand;
  logic hasBase, spaceCodeHigh, spaceCodeMid, spaceCodeLow;
  logic ackCycle, saveStep, fetchStep, swRefused, failAck;
  pev_pkg::pev_cause_t excCause; // cause driven to the design
  pev_pkg::pev_swop_t  swOp;     // status write kind
  logic [2:0]  irqLevel, spaceCode;
  logic [3:0]  trapNum, waitCyc;
  logic [7:0]  vecNum, vecByte;
  logic [15:0] ackData, swOperand, statusWord, savedStatus;
  logic [31:0] baseValue, baseExp;
  logic [23:0] vecAddr;
  int          n_errors, checked;
  assign spaceCode = {spaceCodeHigh, spaceCodeMid, spaceCodeLow};
  pev_vectoring uut
    (
    .sys_clk, .nrst, .clkEn, .excReq, .excCause, .irqLevel, .irqAuto,
    .trapNum, .ackDone, .ackBusErr, .ackData, .saveDone, .fetchDone,
    .swWrite, .swOp, .swOperand, .baseWrite, .baseValue, .refProgram,
    .refOperand, .hasBase, .statusWord, .savedStatus, .spaceCodeHigh,
    .spaceCodeMid, .spaceCodeLow, .vecNum, .vecAddr, .ackCycle,
    .saveStep, .fetchStep, .swRefused
    );
  pev_far_model far
    (
    .sys_clk, .spaceCode, .ackCycle, .saveStep, .fetchStep, .vecByte,
    .failAck, .waitCyc, .ackDone, .ackBusErr, .ackData, .saveDone,
    .fetchDone
    );
  always #50 sys_clk = ~sys_clk;
  // counts a comparison, reports a mismatch
  task automatic check(input logic ok, input string msg);
  begin
    checked++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  end
  endtask
  // prints the counts and the verdict, then stops
  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // one full exception entry, judged on space code, number and address
  task automatic run_exc(input pev_pkg::pev_cause_t c, input logic [2:0] lv,
    input logic au, input logic [3:0] n, input logic [7:0] ev,
    input logic [2:0] fc);
    int i;
    int run;
    logic seen;
    logic [31:0] ea;
  begin
    run = 0;
    seen = 1'b0;
    @(negedge sys_clk);
    excCause = c;
    irqLevel = lv;
    irqAuto = au;
    trapNum = n;
    excReq = 1'b1;
    @(negedge sys_clk);
    excReq = 1'b0;
    for (i = 0; i < 80 && !(seen && !fetchStep); i++)
    begin
      @(posedge sys_clk);
      #1;
      run = fetchStep ? run + 1 : 0;
      if (run == 2)
      begin
        seen = 1'b1;
        check(spaceCode === fc, "fetch space code");
      end
    end
    if (!seen || fetchStep)
    begin
      check(1'b0, "entry did not finish");
      test_done;
    end
    ea = (hasBase ? baseExp : 32'h0) + {22'h0, ev, 2'b00};
    check(vecNum === ev, "vector number");
    check(vecAddr === ea[23:0], "vector address");
  end
  endtask
  // status word write, judged on refusal and resulting value
  task automatic sw_write(input pev_pkg::pev_swop_t op, input logic [15:0] v,
    input logic er, input logic [15:0] es);
    logic rf;
  begin
    @(negedge sys_clk);
    swOp = op;
    swOperand = v;
    swWrite = 1'b1;
    @(negedge sys_clk);
    swWrite = 1'b0;
    rf = swRefused;
    @(negedge sys_clk);
    rf = rf | swRefused;
    check(rf === er, "write refusal");
    check(statusWord === es, "status word");
  end
  endtask
  // sets the reference kind and checks the space code
  task automatic code_is(input logic p, input logic o, input logic [2:0] e);
  begin
    @(negedge sys_clk);
    refProgram = p;
    refOperand = o;
    repeat (2) @(negedge sys_clk);
    check(spaceCode === e, "space code");
  end
  endtask
  // trap entry with operand 3, as used for mode restore
  task automatic trap3;
  begin
    run_exc(pev_pkg::CAUSE_TRAP, 3'h0, 1'b0, 4'h3, 8'h23,
      pev_pkg::SPC_SUPV_DATA);
  end
  endtask
  // reset values seen while reset is held
  task automatic t_reset;
  begin
    nrst = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check(statusWord === 16'h2700, "reset status");
    check(savedStatus === 16'h2700, "reset copy");
    check(spaceCode === pev_pkg::SPC_SUPV_PROG, "reset code");
    check(vecNum === 8'h00 && vecAddr === 24'h0, "reset vector");
    @(negedge sys_clk);
    nrst = 1'b1;
    $display("test reset done");
  end
  endtask
  // every internally numbered cause, plus the reset entry
  task automatic t_fixed;
    int k;
  begin
    // enum order bus error..format error maps to vectors 2..11 then 14
    for (k = 1; k < 12; k++)
      run_exc(pev_pkg::pev_cause_t'(k), 3'h0, 1'b0, 4'h0,
        (k == 11) ? 8'h0e : 8'(k + 1), pev_pkg::SPC_SUPV_DATA);
    run_exc(pev_pkg::CAUSE_TRAP, 3'h0, 1'b0, 4'h0, 8'h20,
      pev_pkg::SPC_SUPV_DATA);
    run_exc(pev_pkg::CAUSE_TRAP, 3'h0, 1'b0, 4'hf, 8'h2f,
      pev_pkg::SPC_SUPV_DATA);
    run_exc(pev_pkg::CAUSE_RESET, 3'h0, 1'b0, 4'h0, 8'h00,
      pev_pkg::SPC_SUPV_PROG);
    $display("test fixed vectors done");
  end
  endtask
  // autovectors, supplied vectors and the spurious case
  task automatic t_irq;
    int k;
  begin
    vecByte = 8'h99;
    for (k = 1; k < 8; k++)
      run_exc(pev_pkg::CAUSE_IRQ, 3'(k), 1'b1, 4'h0, 8'(24 + k),
        pev_pkg::SPC_SUPV_DATA);
    vecByte = 8'h40;
    waitCyc = 4'h5;
    run_exc(pev_pkg::CAUSE_IRQ, 3'h3, 1'b0, 4'h0, 8'h40,
      pev_pkg::SPC_SUPV_DATA);
    waitCyc = 4'h2;
    vecByte = 8'hff;
    run_exc(pev_pkg::CAUSE_IRQ, 3'h7, 1'b0, 4'h0, 8'hff,
      pev_pkg::SPC_SUPV_DATA);
    failAck = 1'b1;
    run_exc(pev_pkg::CAUSE_IRQ, 3'h2, 1'b0, 4'h0, 8'h18,
      pev_pkg::SPC_SUPV_DATA);
    failAck = 1'b0;
    $display("test interrupts done");
  end
  endtask
  // mode changes through the four writes and through entry
  task automatic t_mode;
  begin
    code_is(1'b1, 1'b0, pev_pkg::SPC_SUPV_PROG);
    code_is(1'b0, 1'b0, pev_pkg::SPC_SUPV_DATA);
    sw_write(pev_pkg::SWOP_AND, 16'hdfff, 1'b0, 16'h0700);
    code_is(1'b1, 1'b0, pev_pkg::SPC_USER_PROG);
    code_is(1'b0, 1'b1, pev_pkg::SPC_SUPV_DATA);
    code_is(1'b0, 1'b0, pev_pkg::SPC_USER_DATA);
    sw_write(pev_pkg::SWOP_MOVE, 16'h2700, 1'b1, 16'h0700);
    trap3();
    check(savedStatus === 16'h0700, "saved status");
    check(statusWord === 16'h2700, "entry status");
    sw_write(pev_pkg::SWOP_XOR, 16'h2000, 1'b0, 16'h0700);
    trap3();
    sw_write(pev_pkg::SWOP_MOVE, 16'h0700, 1'b0, 16'h0700);
    trap3();
    sw_write(pev_pkg::SWOP_RETURN, 16'h0700, 1'b1, 16'h2700);
    hasBase = 1'b1;
    sw_write(pev_pkg::SWOP_RETURN, 16'h0700, 1'b0, 16'h0700);
    trap3();
    $display("test modes done");
  end
  endtask
  // vector base added and address cut to the bus width
  task automatic t_base;
  begin
    @(negedge sys_clk);
    baseValue = 32'h1234_5600;
    baseWrite = 1'b1;
    @(negedge sys_clk);
    baseWrite = 1'b0;
    baseExp = 32'h1234_5600;
    trap3();
    hasBase = 1'b0;
    trap3();
    $display("test vector base done");
  end
  endtask
  // clock enable low: a supervisor status write is not taken
  task automatic t_freeze;
  begin
    @(negedge sys_clk);
    clkEn = 1'b0;
    sw_write(pev_pkg::SWOP_MOVE, 16'h0700, 1'b0, 16'h2700);
    clkEn = 1'b1;
    $display("test clock enable done");
  end
  endtask
  // main sequence
  initial
  begin
    {sys_clk, excReq, irqAuto, swWrite, baseWrite, refProgram} = '0;
    {refOperand, hasBase, failAck, nrst} = '0;
    clkEn = 1'b1;
    excCause = pev_pkg::CAUSE_RESET;
    swOp = pev_pkg::SWOP_MOVE;
    {irqLevel, trapNum, vecByte, swOperand, baseValue, baseExp} = '0;
    waitCyc = 4'h2;
    n_errors = 0;
    checked = 0;
    t_reset();
    t_fixed();
    t_irq();
    t_mode();
    t_base();
    t_freeze();
    test_done();
  end
endmodule
`default_nettype wire
